//--- design/bbs_pkg.sv
// Package with constants and types for the branch and bit-set execution block
//
// Overview of operation
// - Branch-if-nonzero jumps only when the zero flag is 0, else falls through.
// - Branch-if-nonzero opcode upper byte 1110 0001, low byte signed offset -128..127.
// - Taken relative branch loads PC with current PC plus 2 plus twice offset.
// - Conditional branch: one word, one cycle untaken, two taken with idle second cycle.
// - Untaken branch decodes, reads offset, processes; fourth phase writes no PC.
// - Always-branch opcode is 1101 then 0, eleven-bit signed offset -1024..1023.
// - Always-branch takes two cycles, PC written in Q4, second cycle idle.
// - Branch-if-no-overflow jumps when overflow clear, else next sequential address.
// - Set-file-bit forces chosen bit 0..7 of the file register, others unchanged.
// - Set-file-bit opcode 1000, then 3-bit index, access flag, 8-bit address.
// - Access flag 0 resolves the address inside the fixed access bank.
// - Access flag 1 takes the bank from the bank selection register.
// - Flag 0 with extended set on and address up to 95 uses indexed offset.
// - None of these instructions changes any arithmetic status flag.
package bbs_pkg;

    // ========================================
    // Widths
    localparam int PC_W = 21;
    localparam int FA_W = 12;
    localparam int RD_W = 16;
    localparam int RA_W = 4;

    // ========================================
    // Opcode patterns
    localparam logic [7:0] OPC_NONZERO_HI = 8'hE1;   // 1110 0001
    localparam logic [7:0] OPC_NOOVF_HI = 8'hE5;     // 1110 0101
    localparam logic [4:0] OPC_ALWAYS = 5'h1A;       // 1101 0
    localparam logic [3:0] OPC_SETBIT = 4'h8;        // 1000

    // ========================================
    // Addressing constants
    localparam logic [7:0] IDX_LIMIT = 8'h5F;    // Highest indexed-offset address
    localparam logic [3:0] ACC_HI_BANK = 4'hF;   // Upper half of access bank
    localparam logic [3:0] ACC_LO_BANK = 4'h0;   // Lower half of access bank
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

    // ========================================
    // Register map (word index on the plain register port)
    localparam logic [RA_W-1:0] REG_CTRL = 4'h0;
    localparam logic [RA_W-1:0] REG_BANKSEL = 4'h1;
    localparam logic [RA_W-1:0] REG_LASTPC = 4'h2;
    localparam logic [RA_W-1:0] REG_TAKEN = 4'h3;
    localparam int CTRL_EXT_BIT = 0;
    localparam logic [RD_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [3:0] BANKSEL_RST = 4'h0;

    // ========================================
    // Types
    typedef enum logic [1:0] {
        BBS_Q1 = 2'b00,
        BBS_Q2 = 2'b01,
        BBS_Q3 = 2'b11,
        BBS_Q4 = 2'b10
    } bbs_phase_t;

    typedef enum logic [2:0] {
        BBS_OP_NONE = 3'h0,
        BBS_OP_NONZERO = 3'h1,
        BBS_OP_NOOVF = 3'h2,
        BBS_OP_ALWAYS = 3'h3,
        BBS_OP_SETBIT = 3'h4
    } bbs_op_t;

endpackage : bbs_pkg

//--- design/bbs_dec_if.sv
// Interface carrying the instruction word to the decoder and its fields back
`timescale 1ns/100ps
interface bbs_dec_if;
    import bbs_pkg::*;
    logic [15:0] word;
    bbs_op_t op;
    logic [PC_W-1:0] offset2;
    logic [2:0] bit_idx;
    logic access;
    logic [7:0] faddr;

    modport dec (input word, output op, offset2, bit_idx, access, faddr);
    modport use_side (output word, input op, offset2, bit_idx, access, faddr);
endinterface : bbs_dec_if

//--- design/bbs_decode.sv
// Combinational decoder for the branch and bit-set instruction group
`timescale 1ns/100ps
module bbs_decode
    import bbs_pkg::*;
(
    bbs_dec_if.dec dif
);

    // ========================================
    // Opcode match and field extraction
    always_comb begin
        dif.op = BBS_OP_NONE;
        dif.offset2 = '0;
        dif.bit_idx = dif.word[11:9];
        dif.access = dif.word[8];
        dif.faddr = dif.word[7:0];
        if (dif.word[15:8] == OPC_NONZERO_HI) begin
            dif.op = BBS_OP_NONZERO;
            // Signed byte doubled: sign copies fill the upper bits
            dif.offset2 = {{(PC_W-9){dif.word[7]}}, dif.word[7:0], 1'b0};
        end else if (dif.word[15:8] == OPC_NOOVF_HI) begin
            dif.op = BBS_OP_NOOVF;
            dif.offset2 = {{(PC_W-9){dif.word[7]}}, dif.word[7:0], 1'b0};
        end else if (dif.word[15:11] == OPC_ALWAYS) begin
            dif.op = BBS_OP_ALWAYS;
            dif.offset2 = {{(PC_W-12){dif.word[10]}}, dif.word[10:0], 1'b0};
        end else if (dif.word[15:12] == OPC_SETBIT) begin
            dif.op = BBS_OP_SETBIT;
        end
    end

endmodule : bbs_decode

//--- design/bbs_exec.sv
// Execution unit for relative branches and the set-file-bit instruction
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module bbs_exec
    import bbs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Instruction issue, sampled in Q1
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic i_zero,
    input wire logic i_ovf,
    // Data memory port
    input wire logic [7:0] i_file_rdata,
    input wire logic [FA_W-1:0] i_fsr2,
    output logic o_file_rd,
    output logic o_file_wr,
    output logic [FA_W-1:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    // Program counter port
    output logic o_pc_wr,
    output logic [PC_W-1:0] o_pc,
    // Sequencing
    output logic [1:0] o_phase,
    output logic o_nop,
    // Register port
    input wire logic [RA_W-1:0] i_reg_addr,
    input wire logic [RD_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [RD_W-1:0] o_reg_rdata
);

    // ========================================
    // Declarations
    bbs_dec_if dif ();
    // Sequencing state
    bbs_phase_t phase_ff;
    bbs_phase_t nxt_phase;
    logic nop_ff;
    logic busy_ff;
    // Captured instruction
    bbs_op_t op_ff;
    logic [PC_W-1:0] pc_ff;
    logic [PC_W-1:0] off2_ff;
    logic [2:0] bit_ff;
    logic zero_ff;
    logic ovf_ff;
    logic taken_ff;
    // Addressing
    logic [FA_W-1:0] addr_ff;
    logic [FA_W-1:0] nxt_addr;
    // Software-visible state
    logic ext_en_ff;
    logic [3:0] banksel_ff;
    logic [PC_W-1:0] last_pc_ff;
    logic [RD_W-1:0] taken_cnt_ff;
    // Combinational helpers
    logic take_now;
    logic set_issue;
    logic exec_q3;
    logic set_write;
    logic branch_taken;
    logic [7:0] set_mask;
    logic [PC_W-1:0] target;

    // ========================================
    // Timeline of one instruction, one clock per quarter:
    //   Q1 edge: word, PC and flags captured; set-file-bit starts its read
    //   Q2: file read strobe and resolved address stand on the data port
    //   Q3 edge: branch decided, target formed, read data merged
    //   Q4: PC write or file write strobe stands for one clock
    // A taken branch then idles a whole instruction cycle, so the core
    // can refill its fetch path; valid is ignored throughout that cycle.
    // An untaken branch leaves Q4 quiet, which keeps the fall-through
    // address owned by the core's own incrementer.

    // ========================================
    // Limitations worth knowing:
    //   Flags are frozen at the Q1 edge; a flag written by the previous
    //   instruction in its Q4 is already settled by then.
    //   The data port has one read and one write per cycle, so the
    //   set-file-bit merge cannot overlap the next instruction's read.
    //   No status flag is driven from here; the core keeps them as they
    //   were across every instruction of this group.
    //   Unknown opcodes still occupy one instruction cycle and do nothing.

    // ========================================
    // Issue and step strobes shared by several processes below
    assign take_now = (phase_ff == BBS_Q1) && i_instr_valid && !nop_ff;
    assign set_issue = take_now && (dif.op == BBS_OP_SETBIT);
    assign exec_q3 = busy_ff && (phase_ff == BBS_Q3);
    assign set_write = exec_q3 && (op_ff == BBS_OP_SETBIT);
    assign dif.word = i_instr;

    // ========================================
    // Decoder
    // Pure decode; all fields come from the live word on the issue edge
    bbs_decode u_decode (
        .dif(dif)
    );

    // ========================================
    // Quarter-phase sequencer, Gray order Q1-Q2-Q3-Q4
    always_comb begin
        case (phase_ff)
            BBS_Q1: nxt_phase = BBS_Q2;
            BBS_Q2: nxt_phase = BBS_Q3;
            BBS_Q3: nxt_phase = BBS_Q4;
            BBS_Q4: nxt_phase = BBS_Q1;
            default: nxt_phase = BBS_Q1;
        endcase
    end

    // Phase register; reset parks the sequencer at Q1
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_ff <= BBS_Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // Port copy of the phase; same next value, so both flops agree
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_phase <= 2'h0;
        end else begin
            o_phase <= nxt_phase;
        end
    end

    // ========================================
    // Instruction capture; flags frozen at cycle start so a late flag
    // update by the core cannot flip the decision mid-cycle
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_ff <= 1'b0;
            op_ff <= BBS_OP_NONE;
            pc_ff <= '0;
            off2_ff <= '0;
            bit_ff <= 3'h0;
            zero_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else if (take_now) begin
            busy_ff <= 1'b1;
            op_ff <= dif.op;
            pc_ff <= i_pc;
            off2_ff <= dif.offset2;
            bit_ff <= dif.bit_idx;
            zero_ff <= i_zero;
            ovf_ff <= i_ovf;
        end else if (phase_ff == BBS_Q4) begin
            busy_ff <= 1'b0;
        end
    end

    // ========================================
    // File address resolution
    // Priority: banked access first, then the indexed window, then the
    // fixed access bank split at the indexed limit. The index add wraps
    // in the twelve-bit space; the core must keep the base in range.
    always_comb begin
        if (dif.access) begin
            nxt_addr = {banksel_ff, dif.faddr};
        end else if (ext_en_ff && (dif.faddr <= IDX_LIMIT)) begin
            nxt_addr = i_fsr2 + {4'h0, dif.faddr};
        end else if (dif.faddr <= IDX_LIMIT) begin
            nxt_addr = {ACC_LO_BANK, dif.faddr};
        end else begin
            nxt_addr = {ACC_HI_BANK, dif.faddr};
        end
    end

    // Address kept for Q3 and Q4 once the word on the input has moved on
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_ff <= '0;
        end else if (set_issue) begin
            addr_ff <= nxt_addr;
        end
    end

    // ========================================
    // Branch decision and target
    always_comb begin
        case (op_ff)
            BBS_OP_NONZERO: branch_taken = !zero_ff;
            BBS_OP_NOOVF: branch_taken = !ovf_ff;
            BBS_OP_ALWAYS: branch_taken = 1'b1;
            default: branch_taken = 1'b0;
        endcase
    end

    // Target wraps in the program counter width, as the core's counter does
    assign target = pc_ff + PC_STEP + off2_ff;
    assign set_mask = 8'h01 << bit_ff;

    // ========================================
    // PC write during Q4; untaken branches leave Q4 idle
    // The target port holds the last target so a slow reader sees it steady
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pc_wr <= 1'b0;
            o_pc <= '0;
            taken_ff <= 1'b0;
        end else if (exec_q3) begin
            o_pc_wr <= branch_taken;
            o_pc <= branch_taken ? target : o_pc;
            taken_ff <= branch_taken;
        end else begin
            o_pc_wr <= 1'b0;
            taken_ff <= (phase_ff == BBS_Q4) ? 1'b0 : taken_ff;
        end
    end

    // ========================================
    // Idle second cycle after any taken branch; no fetch accepted then
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            nop_ff <= 1'b0;
        end else if (phase_ff == BBS_Q4) begin
            nop_ff <= taken_ff && !nop_ff;
        end
    end

    // Port copy of the idle flag; kept apart so the output is a flop
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_nop <= 1'b0;
        end else if (phase_ff == BBS_Q4) begin
            o_nop <= taken_ff && !nop_ff;
        end
    end

    // ========================================
    // File read in Q2, merge in Q3, write in Q4; only the chosen bit
    // changes and no status flag is ever driven from here
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_file_rd <= 1'b0;
            o_file_wr <= 1'b0;
            o_file_addr <= '0;
            o_file_wdata <= 8'h00;
        end else begin
            o_file_rd <= set_issue;
            o_file_addr <= set_issue ? nxt_addr : addr_ff;
            o_file_wr <= set_write;
            if (set_write) begin
                o_file_wdata <= i_file_rdata | set_mask;
            end
        end
    end

    // ========================================
    // Software-written control: extended set enable and bank selection
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_en_ff <= CTRL_RST[CTRL_EXT_BIT];
        end else if (i_reg_wr && (i_reg_addr == REG_CTRL)) begin
            ext_en_ff <= i_reg_wdata[CTRL_EXT_BIT];
        end
    end

    // Bank selection; a change applies from the next set-file-bit issue
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            banksel_ff <= BANKSEL_RST;
        end else if (i_reg_wr && (i_reg_addr == REG_BANKSEL)) begin
            banksel_ff <= i_reg_wdata[3:0];
        end
    end

    // ========================================
    // Status visible to software: last branch target and taken count
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            last_pc_ff <= '0;
            taken_cnt_ff <= '0;
        end else if (exec_q3 && branch_taken) begin
            last_pc_ff <= target;
            taken_cnt_ff <= taken_cnt_ff + 16'h0001;            // Wraps silently
        end
    end

    // ========================================
    // Read data one cycle after the strobe, zero elsewhere
    // Only the low sixteen bits of the last target fit the read port
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= '0;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                REG_CTRL: o_reg_rdata <= {15'h0000, ext_en_ff};
                REG_BANKSEL: o_reg_rdata <= {12'h000, banksel_ff};
                REG_LASTPC: o_reg_rdata <= last_pc_ff[15:0];
                REG_TAKEN: o_reg_rdata <= taken_cnt_ff;
                default: o_reg_rdata <= '0;
            endcase
        end else begin
            o_reg_rdata <= '0;
        end
    end

endmodule : bbs_exec

//--- verif/bbs_exec_properties.sv
// Port assertions for the branch and bit-set execution unit
`timescale 1ns/100ps
module bbs_exec_props
    import bbs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic i_zero,
    input wire logic i_ovf,
    input wire logic [7:0] i_file_rdata,
    input wire logic o_file_rd,
    input wire logic o_file_wr,
    input wire logic [FA_W-1:0] o_file_addr,
    input wire logic [7:0] o_file_wdata,
    input wire logic o_pc_wr,
    input wire logic [PC_W-1:0] o_pc,
    input wire logic [1:0] o_phase,
    input wire logic o_nop
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // =========================================
    // Issue edge: Q1, valid, not idling
    logic take;
    assign take = i_instr_valid && o_phase == 2'b00 && !o_nop;
    chk_pc_phase: assert property (o_pc_wr |-> o_phase == 2'b10)
        else $error("pc write outside fourth quarter");
    chk_rd_phase: assert property (o_file_rd |-> o_phase == 2'b01)
        else $error("file read outside second quarter");
    chk_set_bit: assert property (o_file_rd |-> ##2 (o_file_wr && o_file_wdata ==
        ($past(i_file_rdata) | (8'h01 << $past(i_instr[11:9], 3)))))
        else $error("set bit write data wrong");
    chk_idle_len: assert property (o_pc_wr |=> o_nop [*4] ##1 !o_nop)
        else $error("idle cycle length wrong");
    chk_bra_target: assert property (take && i_instr[15:11] == OPC_ALWAYS |->
        ##3 (o_pc_wr && o_pc == $past(i_pc, 3) + PC_STEP +
        {{9{$past(i_instr[10], 3)}}, $past(i_instr[10:0], 3), 1'b0}))
        else $error("always branch target wrong");
    chk_nz_taken: assert property (take && i_instr[15:8] == OPC_NONZERO_HI |->
        ##3 (o_pc_wr == !$past(i_zero, 3)))
        else $error("nonzero branch decision wrong");
    chk_nov_taken: assert property (take && i_instr[15:8] == OPC_NOOVF_HI |->
        ##3 (o_pc_wr == !$past(i_ovf, 3)))
        else $error("no overflow branch decision wrong");
    chk_untaken_quiet: assert property (take && i_instr[15:8] == OPC_NONZERO_HI && i_zero |->
        ##1 !o_pc_wr [*3] ##1 !o_nop)
        else $error("untaken branch wrote pc or idled");
    chk_acc_bank: assert property (o_file_rd && !$past(i_instr[8]) &&
        $past(i_instr[7:0]) > IDX_LIMIT |-> o_file_addr == {ACC_HI_BANK, $past(i_instr[7:0])})
        else $error("access bank address wrong");
    cov_taken: cover property (o_pc_wr ##1 o_nop);
    cov_set: cover property (o_file_rd ##2 o_file_wr);
    cov_untaken: cover property (take && i_instr[15:8] == OPC_NONZERO_HI && i_zero);
endmodule : bbs_exec_props
bind bbs_exec bbs_exec_props i_props (.i_core_clk, .i_arst_n, .i_instr_valid, .i_instr,
    .i_pc, .i_zero, .i_ovf, .i_file_rdata, .o_file_rd, .o_file_wr, .o_file_addr,
    .o_file_wdata, .o_pc_wr, .o_pc, .o_phase, .o_nop);

//--- verif/bbs_exec_tb.sv
// Self-checking bench for the branch and bit-set execution unit
`timescale 1ns/100ps
module bbs_exec_tb;
    import bbs_pkg::*;
    logic i_core_clk = 1'b0, i_arst_n = 1'b0, i_instr_valid = 1'b0;
    logic i_zero = 1'b0, i_ovf = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [PC_W-1:0] i_pc = '0;
    logic [7:0] i_file_rdata = 8'h00;
    logic [FA_W-1:0] i_fsr2 = '0;
    logic [RA_W-1:0] i_reg_addr = '0;
    logic [RD_W-1:0] i_reg_wdata = '0;
    logic o_file_rd, o_file_wr, o_pc_wr, o_nop;
    logic [FA_W-1:0] o_file_addr;
    logic [7:0] o_file_wdata;
    logic [PC_W-1:0] o_pc, last;
    logic [1:0] o_phase;
    logic [RD_W-1:0] o_reg_rdata;
    logic [31:0] seed = 32'h9C487C76;
    logic [3:0] bs = 4'h0;
    logic ext = 1'b0;
    int fail_count = 0, check_count = 0, cycles = 0, taken_cnt = 0;
    logic [15:0] corner [11] = '{16'hE180, 16'hE17F, 16'hE580, 16'hE57F, 16'hD400,
        16'hD3FF, 16'h8E12, 16'h805F, 16'h8060, 16'hD800, 16'h0000};

    bbs_exec i_bbs_exec (.i_core_clk, .i_arst_n, .i_instr_valid, .i_instr, .i_pc, .i_zero,
        .i_ovf, .i_file_rdata, .i_fsr2, .o_file_rd, .o_file_wr, .o_file_addr, .o_file_wdata,
        .o_pc_wr, .o_pc, .o_phase, .o_nop, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata);

    // =========================================
    // Clock and hang guard
    always #50 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // =========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [PC_W-1:0] tgt(input logic [15:0] w, input logic [PC_W-1:0] p);
        if (w[15:11] == 5'h1A) return p + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0};
        return p + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0};
    endfunction : tgt
    function automatic logic [FA_W-1:0] fad(input logic [15:0] w);
        if (w[8]) return {bs, w[7:0]};
        if (w[7:0] > 8'h5F) return {4'hF, w[7:0]};
        if (ext) return i_fsr2 + {4'h0, w[7:0]};
        return {4'h0, w[7:0]};
    endfunction : fad
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // Register port: one-cycle strobes, data the cycle after a read
    task automatic reg_wr(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [RA_W-1:0] a, input logic [RD_W-1:0] e);
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_core_clk);
        check("reg_rdata", {16'h0, o_reg_rdata}, {16'h0, e});
    endtask : reg_rd
    // Issue one instruction at Q1; valid may linger to prove Q1-only sampling
    task automatic run(input logic [15:0] w);
        logic [31:0] r;
        logic t, s;
        // Step off the edge first so the phase is read settled
        @(negedge i_core_clk);
        while (o_phase !== 2'b10 || o_pc_wr === 1'b1) @(negedge i_core_clk);
        r = rnd();
        t = w[15:11] == 5'h1A || (w[15:8] == 8'hE1 && !r[21]) || (w[15:8] == 8'hE5 && !r[22]);
        s = w[15:12] == 4'h8;
        @(posedge i_core_clk);
        i_instr <= w;
        i_pc <= r[20:0];
        i_zero <= r[21];
        i_ovf <= r[22];
        i_file_rdata <= r[31:24];
        i_fsr2 <= r[31:20];
        i_instr_valid <= 1'b1;
        @(posedge i_core_clk);
        i_instr_valid <= r[23];
        @(negedge i_core_clk);
        check("file_rd", o_file_rd, s);
        if (s) check("file_addr", o_file_addr, fad(w));
        repeat (2) @(negedge i_core_clk);
        check("pc_wr", o_pc_wr, t);
        if (t) check("pc", o_pc, tgt(w, r[20:0]));
        check("file_wr", o_file_wr, s);
        if (s) check("wdata", o_file_wdata, r[31:24] | (8'h01 << w[11:9]));
        // Drop valid before the next Q1 edge so the word is not issued twice
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        @(negedge i_core_clk);
        check("nop", o_nop, t);
        if (t) begin
            taken_cnt++;
            last = tgt(w, r[20:0]);
        end
    endtask : run

    // =========================================
    // Main sequence
    initial begin
        logic [31:0] w;
        repeat (6) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        reg_rd(REG_CTRL, CTRL_RST);
        reg_rd(REG_BANKSEL, {12'h0, BANKSEL_RST});
        reg_wr(4'h7, 16'hFFFF);
        reg_rd(4'h7, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            w = rnd();
            ext = p[0];
            bs = w[3:0];
            reg_wr(REG_CTRL, {15'h0, ext});
            reg_wr(REG_BANKSEL, {12'h0, bs});
            reg_rd(REG_BANKSEL, {12'h0, bs});
            foreach (corner[i]) run(corner[i]);
            repeat (120) begin
                w = rnd();
                case (w[1:0])
                    2'd0: run({8'hE1, w[15:8]});
                    2'd1: run({8'hE5, w[15:8]});
                    2'd2: run({5'h1A, w[26:16]});
                    default: run({4'h8, w[14:3]});
                endcase
            end
        end
        reg_rd(REG_TAKEN, taken_cnt[15:0]);
        reg_rd(REG_LASTPC, last[15:0]);
        report_and_stop();
    end
endmodule : bbs_exec_tb
